// >>> rtl/call_stack_shadow.sv
// Functional notes
// RULE_01: Reset enabled: set flag, then reset device.
// RULE_02: Reset disabled: set flag, no reset.
// RULE_03: Stack flags clear only by software/POR.
// RULE_04: One hidden shadow copy of status/work/bank.
// RULE_05: Every interrupt vectoring saves shadow copy.
// RULE_06: Fast interrupt return restores shadow copy.
// RULE_07: Software saves registers for nested low handlers.
// RULE_08: Fast call saves shadow and pushes return.
// RULE_09: Fast return restores shadow and pops.
// RULE_10: Add working to PC low advances bytes.
// RULE_11: Return-with-literal loads working, pops return.
// RULE_12: Table pointer addresses program memory by byte.
// RULE_13: Each table read moves one byte to latch.
// RULE_14: Interrupt wake pushes PC, advances stack pointer.
// RULE_15: Interrupt wake loads high or low vector.
// RULE_16: Interrupt wake leaves a cause flag set.
// RULE_17: Push at deepest is full; pop empty underflows.
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module call_stack_shadow
    import call_stack_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        porRst,
    // Instruction execution strobes, one cycle each, same clock.
    input  wire logic        callOp,
    input  wire logic        returnOp,
    input  wire logic        intReturnOp,
    input  wire logic        literalReturnOp,
    input  wire logic        fastOption,
    input  wire logic        addPcLowOp,
    input  wire logic        intVector,
    input  wire logic        intHighPri,
    input  wire logic        wakeByInt,
    input  wire logic        globalIntEnableHigh,
    input  wire logic        globalIntEnableLow,
    input  wire logic        tableReadOp,
    input  wire logic [7:0]  literalIn,
    input  wire logic [7:0]  statusIn,
    input  wire logic [7:0]  workingIn,
    input  wire logic [7:0]  bankIn,
    input  wire logic [20:0] pcIn,
    input  wire logic [20:0] targetIn,
    // Program memory byte read path.
    output logic      [20:0] progAddr,
    input  wire logic [15:0] progWord,
    // Outputs to the execution path.
    output logic      [20:0] pcOut,
    output logic             pcLoad,
    output logic      [7:0]  statusOut,
    output logic      [7:0]  workingOut,
    output logic      [7:0]  bankOut,
    output logic             restoreValid,
    output logic             workingLoad,
    output logic             deviceReset,
    output logic             wakeCauseFlag,
    output logic             irq,
    // AXI4-Lite slave.
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic      [1:0]  bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic      [31:0] rdata,
    output logic      [1:0]  rresp,
    output logic             rvalid,
    input  wire logic        rready
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage.

    logic [20:0] retStack [StackDepth];   // Return-address stack.
    logic [4:0]  stackPtr_q;              // Number of stacked entries.
    logic [7:0]  shStatus_q;              // Shadow status copy.
    logic [7:0]  shWorking_q;             // Shadow working copy.
    logic [7:0]  shBank_q;                // Shadow bank select copy.
    logic        resetEn_q;               // Stack error reset enable.
    logic [2:0]  status_q;                // Sticky event flags.
    logic [2:0]  mask_q;                  // Interrupt mask.
    logic [20:0] table_pointer_q;                // Table pointer, byte address.
    logic [7:0]  tblLatch_q;              // Table latch.
    logic        tblPend_q;               // Table read in flight.
    logic        resetReq_q;              // Reset follows the flag.
    logic [20:0] topStack;                // Current top entry.

    // Wake with either global enable acts as a vectoring push.
    logic wakeVector;
    logic pushReq;
    logic popReq;
    logic fullEvt;
    logic underEvt;
    assign wakeVector = wakeByInt && (globalIntEnableHigh || globalIntEnableLow);
    assign pushReq    = callOp || intVector || wakeVector;
    assign popReq     = returnOp || intReturnOp || literalReturnOp;
    // RULE_17: stack error detect
    assign fullEvt    = pushReq && (stackPtr_q == PtrFull);
    assign underEvt   = popReq && (stackPtr_q == PtrReset);
    assign topStack   = (stackPtr_q == PtrReset) ? 21'h000000 : retStack[stackPtr_q - 5'h01];

    ////////////////////////////////////////////////////////////////////////////
    // Return stack pointer and entries.

    // Push stores the current PC; pop drops the top entry.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stackPtr_q <= PtrReset;
        // RULE_14: wake pushes PC
        end else if (pushReq && !fullEvt) begin
            stackPtr_q <= stackPtr_q + 5'h01;
        end else if (popReq && !underEvt) begin
            stackPtr_q <= stackPtr_q - 5'h01;
        end
    end

    // Entry write is on the clock only, no reset needed for data.
    always_ff @(posedge clock) begin
        if (pushReq && !fullEvt) begin
            retStack[stackPtr_q] <= pcIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shadow register set, hidden from the bus.

    // RULE_04: single hidden copy
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shStatus_q  <= 8'h00;
            shWorking_q <= 8'h00;
            shBank_q    <= 8'h00;
        // RULE_05: vectoring saves copy
        end else if (intVector || wakeVector || (callOp && fastOption)) begin
            // RULE_08: fast call saves
            shStatus_q  <= statusIn;
            shWorking_q <= workingIn;
            shBank_q    <= bankIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter and restore outputs, registered.

    // Chooses the next PC for vectors, returns, calls and computed jumps.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pcOut        <= 21'h000000;
            pcLoad       <= 1'b0;
            restoreValid <= 1'b0;
            workingLoad  <= 1'b0;
            statusOut    <= 8'h00;
            workingOut   <= 8'h00;
            bankOut      <= 8'h00;
        end else begin
            pcLoad       <= 1'b0;
            restoreValid <= 1'b0;
            workingLoad  <= 1'b0;
            // RULE_15: vector select
            if (intVector || wakeVector) begin
                pcOut  <= intHighPri ? VecHigh : VecLow;
                pcLoad <= 1'b1;
            end else if (callOp) begin
                pcOut  <= targetIn;
                pcLoad <= 1'b1;
            end else if (popReq && !underEvt) begin
                pcOut  <= topStack;
                pcLoad <= 1'b1;
                // RULE_06: fast return restores
                // RULE_09: fast subroutine restore
                if ((intReturnOp || returnOp) && fastOption) begin
                    statusOut    <= shStatus_q;
                    workingOut   <= shWorking_q;
                    bankOut      <= shBank_q;
                    restoreValid <= 1'b1;
                end
                // RULE_11: literal into working
                if (literalReturnOp) begin
                    workingOut  <= literalIn;
                    workingLoad <= 1'b1;
                end
            // RULE_10: byte offset jump
            end else if (addPcLowOp) begin
                pcOut  <= {pcIn[20:8], pcIn[7:0] + workingIn};
                pcLoad <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Table read: byte address selects half of the program word.

    // RULE_12: byte addressing
    assign progAddr = {table_pointer_q[20:1], 1'b0};

    // RULE_13: one byte per read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tblLatch_q <= 8'h00;
            tblPend_q  <= 1'b0;
        end else begin
            tblPend_q <= tableReadOp;
            if (tblPend_q) begin
                tblLatch_q <= table_pointer_q[0] ? progWord[15:8] : progWord[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Device reset after a flagged stack error.

    // RULE_01: flag first, then reset
    // RULE_02: no reset when disabled
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            resetReq_q  <= 1'b0;
            deviceReset <= 1'b0;
        end else begin
            resetReq_q  <= (fullEvt || underEvt) && resetEn_q;
            deviceReset <= resetReq_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave.

    logic        wrFire;
    logic [31:0] rdMux;
    logic        rdHit;
    assign awready = awvalid && wvalid && !bvalid;
    assign wready  = awready;
    assign wrFire  = awready;
    assign arready = !rvalid;

    // Write response, decoded on acceptance.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bvalid <= 1'b0;
            bresp  <= RespOkay;
        end else if (wrFire) begin
            bvalid <= 1'b1;
            bresp  <= (awaddr == OffCtrl || awaddr == OffStatus || awaddr == OffMask
                       || awaddr == OffTblPtr) ? RespOkay : RespSlvErr;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Control, mask and table pointer writes.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            resetEn_q <= CtrlResetEnInit;
            mask_q    <= MaskInit;
            table_pointer_q  <= 21'h000000;
        end else if (wrFire && wstrb[0]) begin
            if (awaddr == OffCtrl) begin
                resetEn_q <= wdata[CtrlResetEnBit];
            end
            if (awaddr == OffMask) begin
                mask_q <= wdata[2:0];
            end
            if (awaddr == OffTblPtr) begin
                table_pointer_q <= wdata[20:0];
            end
        end
    end

    // Sticky flags: only power-on reset clears, plus write one to clear.
    always_ff @(posedge clock or posedge porRst) begin
        if (porRst) begin
            status_q <= 3'h0;
        end else begin
            // RULE_03: software clear only
            if (wrFire && wstrb[0] && awaddr == OffStatus) begin
                status_q <= status_q & ~wdata[2:0];
            end
            if (fullEvt) begin
                status_q[StFullBit] <= 1'b1;
            end
            if (underEvt) begin
                status_q[StUnderBit] <= 1'b1;
            end
            // RULE_16: wake cause flag
            if (wakeByInt) begin
                status_q[StWakeBit] <= 1'b1;
            end
        end
    end

    assign wakeCauseFlag = status_q[StWakeBit];
    assign irq           = |(status_q & mask_q);

    // Read data selection.
    always_comb begin
        rdMux = 32'h00000000;
        rdHit = 1'b1;
        unique case (araddr)
            OffCtrl:     rdMux = {31'h00000000, resetEn_q};
            OffStatus:   rdMux = {29'h00000000, status_q};
            OffMask:     rdMux = {29'h00000000, mask_q};
            OffTblPtr:   rdMux = {11'h000, table_pointer_q};
            OffTblLatch: rdMux = {24'h000000, tblLatch_q};
            OffStackPtr: rdMux = {27'h0000000, stackPtr_q};
            OffTopStack: rdMux = {11'h000, topStack};
            default:     rdHit = 1'b0;
        endcase
    end

    // Read response register.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= RespOkay;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rdMux;
            rresp  <= rdHit ? RespOkay : RespSlvErr;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    flag_then_reset_a: assert property (@(posedge clock) disable iff (rst) // RULE_01
        (fullEvt && resetEn_q) |-> ##1 status_q[StFullBit] ##1 deviceReset)
        else $error("stack error did not flag then reset");

    no_reset_a: assert property (@(posedge clock) disable iff (rst) // RULE_02
        ((fullEvt || underEvt) && !resetEn_q) |-> ##2 !deviceReset)
        else $error("reset raised while disabled");

    flag_sticky_a: assert property (@(posedge clock) disable iff (rst || porRst) // RULE_03
        (status_q[StUnderBit] && !(wrFire && awaddr == OffStatus)) |=> status_q[StUnderBit])
        else $error("underflow flag lost");

    shadow_save_a: assert property (@(posedge clock) disable iff (rst) // RULE_05
        intVector |=> (shWorking_q == $past(workingIn)))
        else $error("shadow not saved on vector");

    fast_restore_a: assert property (@(posedge clock) disable iff (rst) // RULE_06
        (intReturnOp && fastOption && !underEvt) |=> (restoreValid && statusOut == $past(shStatus_q)))
        else $error("fast return did not restore");

    literal_load_a: assert property (@(posedge clock) disable iff (rst) // RULE_11
        (literalReturnOp && !underEvt) |=> (workingLoad && workingOut == $past(literalIn)))
        else $error("literal not loaded");

    wake_push_a: assert property (@(posedge clock) disable iff (rst) // RULE_14
        (wakeVector && !fullEvt && !popReq) |=> (stackPtr_q == $past(stackPtr_q) + 5'h01))
        else $error("wake did not push");

    wake_vector_a: assert property (@(posedge clock) disable iff (rst) // RULE_15
        (wakeVector && intHighPri) |=> (pcLoad && pcOut == VecHigh))
        else $error("wrong wake vector");

    table_byte_a: assert property (@(posedge clock) disable iff (rst) // RULE_13
        (tableReadOp && !(wrFire && awaddr == OffTblPtr)) |=> ##1
        (tblLatch_q == ($past(table_pointer_q[0], 2) ? $past(progWord[15:8]) : $past(progWord[7:0]))))
        else $error("table byte wrong");

endmodule
`default_nettype wire

// >>> rtl/call_stack_pkg.sv
package call_stack_pkg;

    // Return-address stack geometry.
    localparam int        StackDepth    = 31;
    localparam int        PcWidth       = 21;
    localparam logic [4:0] PtrReset     = 5'h00;
    localparam logic [4:0] PtrFull      = 5'h1f;

    // Interrupt vector addresses.
    localparam logic [20:0] VecHigh     = 21'h000008;
    localparam logic [20:0] VecLow      = 21'h000018;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] OffCtrl      = 8'h00;
    localparam logic [7:0] OffStatus    = 8'h04;
    localparam logic [7:0] OffMask      = 8'h08;
    localparam logic [7:0] OffTblPtr    = 8'h0c;
    localparam logic [7:0] OffTblLatch  = 8'h10;
    localparam logic [7:0] OffStackPtr  = 8'h14;
    localparam logic [7:0] OffTopStack  = 8'h18;

    // Field positions.
    localparam int        CtrlResetEnBit = 0;
    localparam int        StFullBit      = 0;
    localparam int        StUnderBit     = 1;
    localparam int        StWakeBit      = 2;

    // Reset values.
    localparam logic       CtrlResetEnInit = 1'b1;
    localparam logic [2:0] MaskInit        = 3'h0;

    // AXI response codes.
    localparam logic [1:0] RespOkay     = 2'h0;
    localparam logic [1:0] RespSlvErr   = 2'h2;

endpackage

// >>> verification/prog_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Program memory behind the table-read path.
module prog_mem_model (
    input  wire logic        clock,
    input  wire logic        readReq,
    input  wire logic [20:0] progAddr,
    output logic      [15:0] progWord
);
    initial progWord = 16'h0000;
    // two bytes per word
    // A read returns a word of two distinct bytes; otherwise the word toggles so a stale sample shows.
    always @(posedge clock) begin
        if (readReq) begin
            progWord <= {progAddr[8:1] ^ 8'ha5, progAddr[8:1] + 8'h3c};
        end else begin
            progWord <= ~progWord;
        end
    end
endmodule
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", nm, (e), (g)); end end
module tb;
    import call_stack_pkg::*;
    localparam int OpCall = 0, OpRet = 1, OpIret = 2, OpLit = 3, OpAdd = 4, OpVec = 5, OpTbl = 6, OpWake = 7;
    logic clock = 0, rst = 1, porRst = 1, fastOption = 0, intHighPri = 0;
    logic globalIntEnableHigh = 0, globalIntEnableLow = 0;
    logic [7:0] ops = 0, literalIn = 0, statusIn = 0, workingIn = 0, bankIn = 0, awaddr = 0, araddr = 0;
    logic [20:0] pcIn = 0, targetIn = 0, progAddr, pcOut;
    logic [15:0] progWord, seed = 16'h67c2;
    logic [7:0] statusOut, workingOut, bankOut;
    logic pcLoad, restoreValid, workingLoad, deviceReset, wakeCauseFlag, irq;
    logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0, arvalid = 0, arready, rvalid, rready = 0;
    logic [31:0] wdata = 0, rdata, rd, t;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, rsp;
    logic [23:0] sav;
    int n_errors = 0, n_compared = 0, i, hit;

    // Core clock, 5 ns period.
    always #2.5 clock = ~clock;

    call_stack_shadow dut (.*, .callOp(ops[OpCall]), .returnOp(ops[OpRet]), .intReturnOp(ops[OpIret]),
        .literalReturnOp(ops[OpLit]), .addPcLowOp(ops[OpAdd]), .intVector(ops[OpVec]),
        .tableReadOp(ops[OpTbl]), .wakeByInt(ops[OpWake]));
    prog_mem_model mem (.clock(clock), .readReq(ops[OpTbl]), .progAddr(progAddr), .progWord(progWord));

    ////////////////////////////////////////////////////////////////////////////////
    // Galois shift register drives all random stimulus.
    function logic [15:0] rnd();
        seed = seed[0] ? (seed >> 1) ^ 16'hb400 : seed >> 1;
        return seed;
    endfunction

    // Byte expected from a table read at byte address p.
    function automatic logic [7:0] tblByte(input logic [20:0] p);
        return p[0] ? p[8:1] ^ 8'ha5 : p[8:1] + 8'h3c;
    endfunction

    task close_out();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // One AXI4-Lite transfer; waits bounded for the response.
    task axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        logic done;
        done = 0;
        @(posedge clock);
        awaddr <= a; araddr <= a; wdata <= d;
        awvalid <= wr; wvalid <= wr; bready <= wr; arvalid <= !wr; rready <= !wr;
        for (k = 0; k < 40 && !done; k++) begin
            @(posedge clock);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (arready) arvalid <= 0;
            if ((wr && bvalid) || (!wr && rvalid)) begin
                done = 1; bready <= 0; rready <= 0; rd = rdata; rsp = wr ? bresp : rresp;
            end
        end
        if (!done) begin
            n_errors++;
            $display("BAD axi exp 1 got 0");
            close_out();
        end
    endtask

    task rdChk(input logic [7:0] a, input logic [31:0] e);
        axi(0, a, 32'h0);
        `CHK("read", {RespOkay, e}, {rsp, rd})
    endtask

    // One-cycle execution strobe; returns once the registered answer has settled.
    task op(input int b, input logic f);
        @(posedge clock);
        ops <= 8'h01 << b; fastOption <= f;
        @(posedge clock);
        ops <= 8'h00;
        #1;
    endtask

    // Fresh random core registers; the working value stays even for computed jumps.
    task newRegs();
        t = {rnd(), rnd()};
        @(posedge clock);
        statusIn <= t[7:0]; workingIn <= t[15:8] & 8'hfe; bankIn <= t[23:16]; literalIn <= t[31:24];
        pcIn <= {t[4:0], t[31:16]}; targetIn <= t[20:0]; intHighPri <= t[3];
        globalIntEnableHigh <= t[5]; globalIntEnableLow <= !t[5];
        #1;
    endtask

    task restoreChk();
        `CHK("restore", {1'b1, sav}, {restoreValid, statusOut, workingOut, bankOut})
    endtask

    // Counts device reset pulses over four cycles.
    task watchRst();
        hit = 0;
        repeat (4) begin
            @(posedge clock); #1;
            if (deviceReset === 1'b1) hit++;
        end
    endtask

    task rstp(input logic por);
        @(posedge clock);
        rst <= 1; porRst <= por;
        repeat (3) @(posedge clock);
        rst <= 0; porRst <= 0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clock);
        rst <= 0; porRst <= 0;
        rdChk(OffCtrl, 32'h1);
        axi(0, 8'h40, 32'h0); `CHK("unmapped", {RespSlvErr, 32'h0}, {rsp, rd})
        axi(1, OffCtrl, 32'h0); `CHK("bresp", RespOkay, rsp)
        // Only mapped registers are writable: a write off the map is refused.
        axi(1, 8'h40, 32'h0); `CHK("unmapped wr", RespSlvErr, rsp)
        // Stack errors with the reset disabled.
        op(OpRet, 0); `CHK("pop empty", 1'b0, pcLoad)
        watchRst(); `CHK("no reset", 0, hit)
        rdChk(OffStatus, 32'h2);
        for (i = 0; i < 32; i++) begin
            // A refused push still jumps; only the return address is lost.
            op(OpCall, 0); `CHK("push", 1'b1, pcLoad)
        end
        rdChk(OffStatus, 32'h3);
        rdChk(OffStackPtr, {27'h0, PtrFull});
        rstp(0);
        rdChk(OffStatus, 32'h3);
        axi(1, OffStatus, 32'h1);
        rdChk(OffStatus, 32'h2);
        // The ordinary reset brought the reset enable back on.
        op(OpRet, 0); watchRst(); `CHK("stack reset", 1, hit)
        rdChk(OffStatus, 32'h2);
        rstp(1); rdChk(OffStatus, 32'h0);
        // Fast call and fast return.
        for (i = 0; i < 4; i++) begin
            newRegs(); sav = {statusIn, workingIn, bankIn};
            op(OpCall, 1); `CHK("call pc", {1'b1, targetIn}, {pcLoad, pcOut})
            newRegs(); op(OpRet, 1); restoreChk();
        end
        // Vectoring at random priority, returning with and without the fast option.
        for (i = 0; i < 4; i++) begin
            newRegs(); sav = {statusIn, workingIn, bankIn};
            op(OpVec, 0); `CHK("vector", intHighPri ? VecHigh : VecLow, pcOut)
            newRegs(); op(OpIret, i[0]);
            if (i[0]) restoreChk();
            else `CHK("no restore", 1'b0, restoreValid)
        end
        // Nested vectoring leaves only the later copy.
        newRegs(); op(OpVec, 0);
        newRegs(); sav = {statusIn, workingIn, bankIn}; op(OpVec, 0);
        newRegs(); op(OpIret, 1); restoreChk();
        op(OpIret, 1); restoreChk();
        // Computed jump with an even offset, then a literal return.
        op(OpCall, 0); newRegs();
        op(OpAdd, 0); `CHK("jump", {1'b1, pcIn[20:8], pcIn[7:0] + workingIn}, {pcLoad, pcOut})
        newRegs(); op(OpLit, 0); `CHK("literal", {1'b1, literalIn}, {workingLoad, workingOut})
        // Table reads at odd and even byte addresses.
        for (i = 0; i < 6; i++) begin
            t = {rnd(), rnd()};
            axi(1, OffTblPtr, {11'h0, t[20:1], i[0]});
            `CHK("addr", {t[20:1], 1'b0}, progAddr)
            op(OpTbl, 0); repeat (2) @(posedge clock);
            rdChk(OffTblLatch, {24'h0, tblByte({t[20:1], i[0]})});
        end
        // Wake by interrupt: masked first, then unmasked, then cleared.
        newRegs(); op(OpWake, 0);
        `CHK("wake pc", {1'b1, intHighPri ? VecHigh : VecLow}, {pcLoad, pcOut})
        `CHK("wake flag", 2'b10, {wakeCauseFlag, irq})
        rdChk(OffStackPtr, 32'h1);
        rdChk(OffTopStack, {11'h0, pcIn});
        axi(1, OffMask, 32'h4); `CHK("irq", 1'b1, irq)
        axi(1, OffStatus, 32'h4); `CHK("irq clear", 2'b00, {wakeCauseFlag, irq})
        // Wake with both global enables off: flag only, no vector and no push.
        @(posedge clock);
        globalIntEnableHigh <= 0;
        globalIntEnableLow <= 0;
        op(OpWake, 0); `CHK("wake off", 3'b011, {pcLoad, wakeCauseFlag, irq})
        rdChk(OffStackPtr, 32'h1);
        op(OpRet, 0);
        close_out();
    end
endmodule
`default_nettype wire
